// ---- logic/serial_port.sv ----
// Enhanced serial port with four modes and an APB register slave
//
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module serial_port (
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic serialTxPin,
  input wire logic serialRxIn,
  output logic serialRxOut,
  output logic serialRxOe
);
  import serial_port_pkg::*;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] baud;
    logic [7:0] t1Reload;
    logic [15:0] t2Reload;
    logic [7:0] slaveAddr;
    logic [7:0] slaveMask;
    logic overrun;
    logic unread;
    logic [3:0] t1Pre;
    logic [7:0] t1Cnt;
    logic t1Half;
    logic t2Pre;
    logic [15:0] t2Cnt;
    logic [1:0] m2Pre;
    tx_state_e txState;
    logic [10:0] txShift;
    logic [3:0] txBits;
    logic [3:0] txSub;
    rx_state_e rxState;
    logic [3:0] rxSub;
    logic [3:0] rxCnt;
    logic [7:0] rxShift;
    logic rxNinthTmp;
    logic [7:0] rxBuf;
    logic [3:0] m0Cnt;
    logic prevRx;
    logic txPin;
    logic rxOe;
    logic [31:0] rdData;
    logic rdErr;
  } state_s;

  state_s state_q;
  state_s state_d;

  function automatic logic addrMatch(input logic [7:0] rx,
                                     input logic [7:0] addr,
                                     input logic [7:0] mask);
    addrMatch = ((rx ^ addr) & mask) == 8'h00;
  endfunction : addrMatch

  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a == ADDR_CTRL) || (a == ADDR_DATA) || (a == ADDR_BAUD) ||
               (a == ADDR_T1_RELOAD) || (a == ADDR_T2_RELOAD) ||
               (a == ADDR_SLAVE) || (a == ADDR_STATUS);
  endfunction : isMapped

  logic [1:0] mode;
  logic doubler;
  logic txT2;
  logic rxT2;
  logic setup;
  logic wr;
  logic rd;
  logic t1Step;
  logic t1Ovf;
  logic t1Tick;
  logic t2Step;
  logic t2Ovf;
  logic m2Tick;
  logic tickTx;
  logic tickRx;
  logic rxBit;
  logic ninthNow;
  logic accept;

  always_comb begin
    state_d = state_q;
    mode = state_q.ctrl[CTRL_MODE_LSB +: 2];
    doubler = state_q.baud[BAUD_DOUBLER];
    txT2 = state_q.baud[BAUD_TX_T2];
    rxT2 = state_q.baud[BAUD_RX_T2];
    setup = psel && !penable;
    wr = psel && penable && pwrite;
    rd = psel && penable && !pwrite;
    rxBit = serialRxIn;
    ninthNow = 1'b0;
    accept = 1'b0;

    // Timer 1: 8-bit auto-reload, clock/12 or clock
    t1Step = state_q.baud[BAUD_T1_PRESCALE] ||
             (state_q.t1Pre == T1_PRESCALE_LAST);
    state_d.t1Pre = (state_q.t1Pre == T1_PRESCALE_LAST) ? 4'h0
                    : state_q.t1Pre + 4'h1;
    t1Ovf = t1Step && (state_q.t1Cnt == 8'hFF);
    if (t1Ovf) begin
      state_d.t1Cnt = state_q.t1Reload;
    end else if (t1Step) begin
      state_d.t1Cnt = state_q.t1Cnt + 8'h01;
    end
    // Without the doubler only every second overflow counts
    if (t1Ovf) begin
      state_d.t1Half = !state_q.t1Half;
    end
    t1Tick = t1Ovf && (doubler || state_q.t1Half);

    // Timer 2: runs only when routed, forced to baud mode at clock/2
    t2Step = (txT2 || rxT2) && state_q.t2Pre;
    state_d.t2Pre = (txT2 || rxT2) ? !state_q.t2Pre : 1'b0;
    t2Ovf = t2Step && (state_q.t2Cnt == 16'hFFFF);
    if (t2Ovf) begin
      state_d.t2Cnt = state_q.t2Reload;
    end else if (t2Step) begin
      state_d.t2Cnt = state_q.t2Cnt + 16'h0001;
    end

    // Fixed mode 2 clock: 16 subticks per bit of clock/64 or clock/32
    m2Tick = state_q.m2Pre == (doubler ? M2_PRE_FAST : M2_PRE_SLOW);
    state_d.m2Pre = m2Tick ? 2'h0 : state_q.m2Pre + 2'h1;

    // Transmit and receive pick their timers separately
    tickTx = (mode == 2'd2) ? m2Tick : (txT2 ? t2Ovf : t1Tick);
    tickRx = (mode == 2'd2) ? m2Tick : (rxT2 ? t2Ovf : t1Tick);

    // APB: read data captured in setup, answered with no wait state
    if (setup) begin
      state_d.rdErr = !isMapped(paddr);
      state_d.rdData = 32'h0000_0000;
      unique case (paddr)
        ADDR_CTRL: state_d.rdData[7:0] = state_q.ctrl;
        ADDR_DATA: state_d.rdData[7:0] = state_q.rxBuf;
        ADDR_BAUD: state_d.rdData[7:0] = state_q.baud;
        ADDR_T1_RELOAD: state_d.rdData[7:0] = state_q.t1Reload;
        ADDR_T2_RELOAD: state_d.rdData[15:0] = state_q.t2Reload;
        ADDR_SLAVE: state_d.rdData[15:0] = {state_q.slaveMask,
                                            state_q.slaveAddr};
        ADDR_STATUS: begin
          state_d.rdData[STAT_OVERRUN] = state_q.overrun;
          state_d.rdData[STAT_TX_BUSY] = state_q.txState != TX_IDLE;
          state_d.rdData[STAT_RX_BUSY] = state_q.rxState != RX_IDLE;
        end
        default: state_d.rdData = 32'h0000_0000;
      endcase
    end
    if (rd && paddr == ADDR_DATA) begin
      state_d.unread = 1'b0;
    end
    if (wr) begin
      unique case (paddr)
        ADDR_CTRL: state_d.ctrl = pwdata[7:0];
        ADDR_BAUD: state_d.baud = pwdata[7:0];
        ADDR_T1_RELOAD: begin
          // Count restarts too, so the first baud period is full length
          state_d.t1Reload = pwdata[7:0];
          state_d.t1Cnt = pwdata[7:0];
        end
        ADDR_T2_RELOAD: begin
          state_d.t2Reload = pwdata[15:0];
          state_d.t2Cnt = pwdata[15:0];
        end
        ADDR_SLAVE: begin
          state_d.slaveAddr = pwdata[7:0];
          state_d.slaveMask = pwdata[15:8];
        end
        ADDR_STATUS: begin
          if (pwdata[STAT_OVERRUN]) begin
            state_d.overrun = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // Transmitter; a data write while busy is dropped
    unique case (state_q.txState)
      TX_IDLE: begin
        if (wr && paddr == ADDR_DATA) begin
          state_d.txSub = 4'h0;
          state_d.m0Cnt = 4'h0;
          if (mode == 2'd0) begin
            // Half duplex: a write while a receive is already shifting is dropped
            if (state_q.rxState == RX_IDLE) begin
              state_d.txState = TX_SYNC;
              state_d.txShift = {3'b111, pwdata[7:0]};
              state_d.txBits = 4'h8;
            end
          end else begin
            state_d.txState = TX_ASYNC;
            if (mode == 2'd1) begin
              state_d.txShift = {2'b11, pwdata[7:0], 1'b0};
              state_d.txBits = FRAME_BITS_8;
            end else begin
              state_d.txShift = {1'b1, state_q.ctrl[CTRL_TX_NINTH],
                                 pwdata[7:0], 1'b0};
              state_d.txBits = FRAME_BITS_9;
            end
          end
        end
      end
      TX_ASYNC: begin
        if (tickTx) begin
          state_d.txSub = state_q.txSub + 4'h1;
          if (state_q.txSub == SUB_LAST) begin
            state_d.txShift = {1'b1, state_q.txShift[10:1]};
            state_d.txBits = state_q.txBits - 4'h1;
            if (state_q.txBits == 4'h2) begin
              state_d.ctrl[CTRL_TX_DONE] = 1'b1;
            end
            if (state_q.txBits == 4'h1) begin
              state_d.txState = TX_IDLE;
            end
          end
        end
      end
      TX_SYNC: begin
        state_d.m0Cnt = (state_q.m0Cnt == MODE0_LAST) ? 4'h0
                        : state_q.m0Cnt + 4'h1;
        if (state_q.m0Cnt == MODE0_LAST) begin
          state_d.txShift = {1'b1, state_q.txShift[10:1]};
          state_d.txBits = state_q.txBits - 4'h1;
          if (state_q.txBits == 4'h1) begin
            state_d.ctrl[CTRL_TX_DONE] = 1'b1;
            state_d.txState = TX_IDLE;
          end
        end
      end
      default: state_d.txState = TX_IDLE;
    endcase

    // Receiver
    state_d.prevRx = rxBit;
    unique case (state_q.rxState)
      RX_IDLE: begin
        state_d.rxSub = 4'h0;
        state_d.rxCnt = 4'h0;
        if (mode == 2'd0) begin
          if (state_q.ctrl[CTRL_RX_ENABLE] && !state_q.ctrl[CTRL_RX_DONE] &&
              state_q.txState == TX_IDLE &&
              !(wr && paddr == ADDR_DATA)) begin
            state_d.rxState = RX_SYNC;
            state_d.m0Cnt = 4'h0;
          end
        end else if (state_q.ctrl[CTRL_RX_ENABLE] && state_q.prevRx &&
                     !rxBit) begin
          state_d.rxState = RX_START;
        end
      end
      RX_START: begin
        if (tickRx) begin
          state_d.rxSub = state_q.rxSub + 4'h1;
          if (state_q.rxSub == SUB_MID) begin
            // A glitch that is high again at mid start bit is dropped
            state_d.rxState = rxBit ? RX_IDLE : RX_BITS;
            state_d.rxSub = 4'h0;
          end
        end
      end
      RX_BITS: begin
        if (tickRx) begin
          state_d.rxSub = state_q.rxSub + 4'h1;
          if (state_q.rxSub == SUB_LAST) begin
            state_d.rxCnt = state_q.rxCnt + 4'h1;
            if (state_q.rxCnt < RX_NINTH_IDX) begin
              state_d.rxShift = {rxBit, state_q.rxShift[7:1]};
            end
            if (state_q.rxCnt == RX_NINTH_IDX) begin
              state_d.rxNinthTmp = rxBit;
            end
            ninthNow = (state_q.rxCnt == RX_NINTH_IDX) ? rxBit
                       : state_q.rxNinthTmp;
            if ((mode == 2'd1 && state_q.rxCnt == RX_NINTH_IDX) ||
                (mode != 2'd1 && state_q.rxCnt == RX_LAST_9)) begin
              state_d.rxState = RX_IDLE;
              if (mode == 2'd1) begin
                accept = !state_q.ctrl[CTRL_ADDR_FILTER] || ninthNow;
              end else begin
                accept = !state_q.ctrl[CTRL_ADDR_FILTER] ||
                         (ninthNow && addrMatch(state_q.rxShift,
                                                state_q.slaveAddr,
                                                state_q.slaveMask));
              end
              accept = accept && !state_q.ctrl[CTRL_RX_DONE];
            end
          end
        end
      end
      RX_SYNC: begin
        state_d.m0Cnt = (state_q.m0Cnt == MODE0_LAST) ? 4'h0
                        : state_q.m0Cnt + 4'h1;
        if (state_q.m0Cnt == MODE0_RISE) begin
          state_d.rxShift = {rxBit, state_q.rxShift[7:1]};
          state_d.rxCnt = state_q.rxCnt + 4'h1;
          if (state_q.rxCnt == 4'h7) begin
            state_d.rxState = RX_SYNC_END;
          end
        end
      end
      RX_SYNC_END: begin
        state_d.rxState = RX_IDLE;
        state_d.rxBuf = state_q.rxShift;
        state_d.ctrl[CTRL_RX_DONE] = 1'b1;
        state_d.unread = 1'b1;
        if (state_q.unread) begin
          state_d.overrun = 1'b1;
        end
      end
      default: state_d.rxState = RX_IDLE;
    endcase

    // Hardware sets come after software writes so a set is never lost
    if (accept) begin
      state_d.rxBuf = state_q.rxShift;
      state_d.ctrl[CTRL_RX_NINTH] = ninthNow;
      state_d.ctrl[CTRL_RX_DONE] = 1'b1;
      state_d.unread = 1'b1;
      if (state_q.unread) begin
        state_d.overrun = 1'b1;
      end
    end

    // Pins from next state: mode 0 clock idles high on the tx pin
    if (state_d.txState == TX_SYNC || state_d.rxState == RX_SYNC) begin
      state_d.txPin = state_d.m0Cnt >= MODE0_RISE;
    end else if (state_d.txState == TX_ASYNC) begin
      state_d.txPin = state_d.txShift[0];
    end else begin
      state_d.txPin = 1'b1;
    end
    state_d.rxOe = (state_d.txState == TX_SYNC) &&
                   !state_d.txShift[0];
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= '0;
      state_q.ctrl <= CTRL_RESET;
      state_q.baud <= BAUD_RESET;
      state_q.txState <= TX_IDLE;
      state_q.rxState <= RX_IDLE;
      state_q.txShift <= 11'h7FF;
      // Idle-high line, so reset gives no false start edge
      state_q.prevRx <= 1'b1;
      state_q.txPin <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  assign prdata = state_q.rdData;
  // Registers answer at once: zero wait states
  assign pready = 1'b1;
  assign pslverr = state_q.rdErr;
  assign serialTxPin = state_q.txPin;
  // Open-drain: only ever pulls low
  assign serialRxOut = 1'b0;
  assign serialRxOe = state_q.rxOe;

endmodule : serial_port
`default_nettype wire

// ---- logic/serial_port_pkg.sv ----
// Constants, register map and state types of the enhanced serial port
package serial_port_pkg;

  // APB byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DATA = 8'h04;
  localparam logic [7:0] ADDR_BAUD = 8'h08;
  localparam logic [7:0] ADDR_T1_RELOAD = 8'h0C;
  localparam logic [7:0] ADDR_T2_RELOAD = 8'h10;
  localparam logic [7:0] ADDR_SLAVE = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;

  // serial_control_reg fields
  localparam int CTRL_RX_DONE = 0;
  localparam int CTRL_TX_DONE = 1;
  localparam int CTRL_RX_NINTH = 2;
  localparam int CTRL_TX_NINTH = 3;
  localparam int CTRL_RX_ENABLE = 4;
  localparam int CTRL_ADDR_FILTER = 5;
  localparam int CTRL_MODE_LSB = 6;
  // Baud control fields
  localparam int BAUD_DOUBLER = 0;
  localparam int BAUD_T1_PRESCALE = 1;
  localparam int BAUD_TX_T2 = 4;
  localparam int BAUD_RX_T2 = 5;
  // Status fields
  localparam int STAT_OVERRUN = 0;
  localparam int STAT_TX_BUSY = 1;
  localparam int STAT_RX_BUSY = 2;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] BAUD_RESET = 8'h00;

  // Cycle counts
  localparam logic [3:0] MODE0_LAST = 4'hB;     // 12 clocks per bit
  localparam logic [3:0] MODE0_RISE = 4'h6;     // Shift clock rises here
  localparam logic [3:0] T1_PRESCALE_LAST = 4'hB; // Clock/12 prescale
  localparam logic [1:0] M2_PRE_SLOW = 2'h3;    // 16x of clock/64
  localparam logic [1:0] M2_PRE_FAST = 2'h1;    // 16x of clock/32
  localparam logic [3:0] SUB_MID = 4'h7;
  localparam logic [3:0] SUB_LAST = 4'hF;
  localparam logic [3:0] FRAME_BITS_8 = 4'hA;
  localparam logic [3:0] FRAME_BITS_9 = 4'hB;
  localparam logic [3:0] RX_NINTH_IDX = 4'h8;
  localparam logic [3:0] RX_LAST_9 = 4'h9;

  typedef enum logic [1:0] {TX_IDLE, TX_ASYNC, TX_SYNC} tx_state_e;
  typedef enum logic [2:0] {
    RX_IDLE, RX_START, RX_BITS, RX_SYNC, RX_SYNC_END
  } rx_state_e;

endpackage : serial_port_pkg

// ---- verif/serial_peer.sv ----
// Remote serial device: async sender and mode 0 shift slave
`timescale 1ns/1ps
`default_nettype none
module serial_peer (
  input wire logic clk,
  input wire logic shiftClk,
  input wire logic rxOe,
  input wire logic rxOut,
  output logic rxLine
);
  logic asyncBit = 1'b1;
  logic [7:0] shiftData = 8'hFF;
  int shiftLeft = 0;
  // Pull-up holds the line high when nobody drives it
  assign rxLine = rxOe ? rxOut
    : asyncBit && (shiftLeft == 0 || shiftData[0]);
  // Next bit one clock after each rise, once the master has sampled
  always @(posedge shiftClk) begin
    @(posedge clk);
    if (shiftLeft > 0) begin
      shiftData <= shiftData >> 1;
      shiftLeft <= shiftLeft - 1;
    end
  end
  task automatic load(input logic [7:0] d);
    shiftData <= d;
    shiftLeft <= 8;
  endtask : load
  // Start bit, payload bits LSB first, then one idle bit time
  task automatic send(input logic [9:0] bits, input int nb, input int per);
    int i;
    asyncBit <= 1'b0;
    repeat (per) @(posedge clk);
    for (i = 0; i < nb; i++) begin
      asyncBit <= bits[i];
      repeat (per) @(posedge clk);
    end
    asyncBit <= 1'b1;
    repeat (per) @(posedge clk);
  endtask : send
endmodule : serial_peer
`default_nettype wire

// ---- verif/serial_port_properties.sv ----
// Pin timing checks of the serial port, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module serial_port_properties
  import serial_port_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic serialTxPin,
  input wire logic serialRxIn,
  input wire logic serialRxOut,
  input wire logic serialRxOe
);
  logic [1:0] modeQ;
  logic [7:0] baudQ;
  logic [7:0] reloadOneQ;
  logic [15:0] reloadTwoQ;
  logic prevPinQ;
  logic [31:0] runQ;
  logic [31:0] bitLen;
  logic wrEn;
  logic [31:0] runRem;
  logic bitEdgeOk;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  assign wrEn = psel && penable && pwrite;
  // A start bit ends on its sixteenth tick and the first tick may come
  // early, so its run may fall short of whole bits by less than a tick
  assign runRem = runQ % bitLen;
  assign bitEdgeOk = runRem == 32'h0 || runRem > bitLen - (bitLen >> 4);
  // Shadow of software settings; the frame in flight is never reconfigured
  always_ff @(posedge clk) begin
    if (srst) begin
      modeQ <= 2'h0;
      baudQ <= 8'h00;
      reloadOneQ <= 8'h00;
      reloadTwoQ <= 16'h0000;
      prevPinQ <= 1'b1;
      runQ <= 32'h0;
    end else begin
      if (wrEn && paddr == ADDR_CTRL) modeQ <= pwdata[7:6];
      if (wrEn && paddr == ADDR_BAUD) baudQ <= pwdata[7:0];
      if (wrEn && paddr == ADDR_T1_RELOAD) reloadOneQ <= pwdata[7:0];
      if (wrEn && paddr == ADDR_T2_RELOAD) reloadTwoQ <= pwdata[15:0];
      prevPinQ <= serialTxPin;
      runQ <= (serialTxPin != prevPinQ) ? 32'h1 : runQ + 32'h1;
    end
  end
  // Low runs inside a frame are whole bit times, or less than a tick short when they hold the start bit
  always_comb begin
    if (modeQ == 2'h2) bitLen = baudQ[BAUD_DOUBLER] ? 32'h20 : 32'h40;
    else if (baudQ[BAUD_TX_T2]) bitLen = 32'h20 * (32'h10000 - reloadTwoQ);
    else bitLen = 32'h10 * (32'h100 - reloadOneQ)
      * (baudQ[BAUD_DOUBLER] ? 32'h1 : 32'h2)
      * (baudQ[BAUD_T1_PRESCALE] ? 32'h1 : 32'hC);
  end
  property p_m0_low;
    $fell(serialTxPin) && modeQ == 2'h0 |->
      !serialTxPin [*6] ##1 serialTxPin;
  endproperty
  a_m0_low: assert property (p_m0_low)
    else $error("mode 0 shift clock low phase wrong");
  property p_m0_high;
    $rose(serialTxPin) && modeQ == 2'h0 |-> serialTxPin [*6];
  endproperty
  a_m0_high: assert property (p_m0_high)
    else $error("mode 0 shift clock high phase wrong");
  property p_oe_mode0;
    serialRxOe |-> modeQ == 2'h0;
  endproperty
  a_oe_mode0: assert property (p_oe_mode0)
    else $error("receive pin driven outside mode 0");
  property p_open_drain;
    serialRxOut == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("receive pin driven high");
  property p_rate_fixed;
    serialTxPin && !prevPinQ && modeQ == 2'h2 |-> bitEdgeOk;
  endproperty
  a_rate_fixed: assert property (p_rate_fixed)
    else $error("mode 2 bit time wrong");
  property p_rate_t1;
    serialTxPin && !prevPinQ && modeQ[0] && !baudQ[BAUD_TX_T2] |->
      bitEdgeOk;
  endproperty
  a_rate_t1: assert property (p_rate_t1)
    else $error("timer 1 bit time wrong");
  property p_rate_t2;
    serialTxPin && !prevPinQ && modeQ[0] && baudQ[BAUD_TX_T2] |->
      bitEdgeOk;
  endproperty
  a_rate_t2: assert property (p_rate_t2)
    else $error("timer 2 bit time wrong");
  property p_reset_idle;
    $fell(srst) |-> serialTxPin && !serialRxOe;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("pins not idle after reset");
  c_m0: cover property ($fell(serialTxPin) && modeQ == 2'h0);
  c_fixed: cover property (serialTxPin && !prevPinQ && modeQ == 2'h2);
  c_oe: cover property (serialRxOe);
endmodule : serial_port_properties
bind serial_port serial_port_properties chk (.clk, .srst, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .serialTxPin,
  .serialRxIn, .serialRxOut, .serialRxOe);
`default_nettype wire

// ---- verif/serial_port_tb.sv ----
// Self-checking bench for the serial port over APB and its pins
`timescale 1ns/1ps
`default_nettype none
module serial_port_tb;
  import serial_port_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic serialTxPin;
  logic serialRxOut;
  logic serialRxOe;
  wire logic rxLine;
  int errCount = 0;
  int checksDone = 0;
  logic [7:0] cfgCtrl [5] = '{8'h88, 8'h80, 8'h40, 8'h40, 8'hC8};
  logic [7:0] cfgBaud [5] = '{8'h01, 8'h00, 8'h03, 8'h13, 8'h02};
  int cfgPer [5] = '{32, 64, 32, 32, 64};
  logic [9:0] rxBits [3] = '{10'h3C5, 10'h2C5, 10'h3C4};
  serial_port dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serialTxPin(serialTxPin),
    .serialRxIn(rxLine), .serialRxOut(serialRxOut),
    .serialRxOe(serialRxOe));
  serial_peer peer (.clk(clk), .shiftClk(serialTxPin), .rxOe(serialRxOe),
    .rxOut(serialRxOut), .rxLine(rxLine));
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checksDone, errCount);
    if (errCount == 0 && checksDone > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      errCount++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] wd, output logic [31:0] rd, output logic er);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so the next setup never reassigns psel in this step
    @(posedge clk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    logic e;
    apb(1'b0, a, 32'h0, v, e);
  endtask : rd
  // Wait for the start bit, then sample each bit in its middle
  task automatic frame(input int per, input int n, output logic [10:0] f);
    int k;
    f = '0;
    for (k = 0; k < 4000 && serialTxPin !== 1'b0; k++) @(posedge clk);
    repeat (per / 2) @(posedge clk);
    for (k = 0; k < n; k++) begin
      f[k] = serialTxPin;
      repeat (per) @(posedge clk);
    end
  endtask : frame
  initial begin
    repeat (40000) @(posedge clk);
    errCount++;
    end_of_test();
  end
  initial begin
    logic [31:0] v;
    logic e;
    logic [10:0] f;
    logic [7:0] d;
    int i;
    int n;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd(ADDR_CTRL, v);
    chk(v, 32'h0);
    rd(ADDR_STATUS, v);
    chk(v, 32'h0);
    apb(1'b0, 8'h1C, 32'h0, v, e);
    chk({31'h0, e}, 32'h1);
    wr(ADDR_T1_RELOAD, 32'hFE);
    wr(ADDR_T2_RELOAD, 32'hFFFF);
    wr(ADDR_SLAVE, 32'h0F35);
    for (i = 0; i < 5; i++) begin
      d = 8'hA5 ^ 8'(i * 17);
      n = cfgCtrl[i][7] ? 11 : 10;
      wr(ADDR_BAUD, {24'h0, cfgBaud[i]});
      wr(ADDR_CTRL, {24'h0, cfgCtrl[i]});
      wr(ADDR_DATA, {24'h0, d});
      rd(ADDR_CTRL, v);
      chk(v & 32'h2, 32'h0);
      rd(ADDR_STATUS, v);
      chk(v & 32'h2, 32'h2);
      frame(cfgPer[i], n, f);
      if (n == 10) chk({21'h0, f}, {23'h1, d, 1'b0});
      else chk({21'h0, f}, {22'h1, cfgCtrl[i][3], d, 1'b0});
      rd(ADDR_CTRL, v);
      chk(v & 32'h2, 32'h2);
    end
    // Mode 1 receive with double buffer, overrun and filter
    wr(ADDR_BAUD, 32'h23);
    wr(ADDR_CTRL, 32'h50);
    peer.send(10'h13C, 9, 32);
    rd(ADDR_CTRL, v);
    chk(v & 32'h5, 32'h5);
    rd(ADDR_DATA, v);
    chk(v, 32'h3C);
    peer.send(10'h1C3, 9, 32);
    rd(ADDR_CTRL, v);
    chk(v & 32'h1, 32'h1);
    rd(ADDR_DATA, v);
    chk(v, 32'h3C);
    wr(ADDR_CTRL, 32'h50);
    peer.send(10'h166, 9, 32);
    wr(ADDR_CTRL, 32'h50);
    peer.send(10'h199, 9, 32);
    rd(ADDR_STATUS, v);
    chk(v & 32'h1, 32'h1);
    rd(ADDR_DATA, v);
    chk(v, 32'h99);
    wr(ADDR_CTRL, 32'h70);
    peer.send(10'h011, 9, 32);
    rd(ADDR_CTRL, v);
    chk(v & 32'h1, 32'h0);
    // Mode 2 address filter: match, ninth clear, masked mismatch
    wr(ADDR_BAUD, 32'h01);
    for (i = 0; i < 3; i++) begin
      wr(ADDR_CTRL, 32'hB0);
      peer.send(rxBits[i], 10, 32);
      rd(ADDR_CTRL, v);
      chk(v & 32'h5, (i == 0) ? 32'h5 : 32'h0);
    end
    rd(ADDR_DATA, v);
    chk(v, 32'hC5);
    // Mode 0 transmit then receive
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_DATA, 32'h96);
    for (i = 0; i < 8; i++) begin
      @(posedge serialTxPin);
      d[i] = rxLine;
    end
    chk({24'h0, d}, 32'h96);
    repeat (12) @(posedge clk);
    rd(ADDR_CTRL, v);
    chk(v & 32'h2, 32'h2);
    peer.load(8'h5A);
    wr(ADDR_CTRL, 32'h10);
    v = 32'h0;
    for (i = 0; i < 100 && v[0] !== 1'b1; i++) rd(ADDR_CTRL, v);
    rd(ADDR_DATA, v);
    chk(v, 32'h5A);
    n = 0;
    repeat (48) begin
      @(posedge clk);
      if (serialTxPin !== 1'b1) n++;
    end
    chk(32'(n), 32'h0);
    end_of_test();
  end
endmodule : serial_port_tb
`default_nettype wire
